// >>> verilog/ofmec_defines.vh
// register map, field positions, reset values and codes of the mode block
`ifndef OFMEC_DEFINES_VH
`define OFMEC_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFMEC_REG_SLOW_TRIM 8'h18
`define OFMEC_REG_FAST_TRIM 8'h1A
`define OFMEC_REG_ON_THR    8'h2A
`define OFMEC_REG_OFF_THR   8'h2B
`define OFMEC_REG_ASW_THR   8'h2C
`define OFMEC_REG_GTRIG     8'h3E
`define OFMEC_REG_SAMP      8'h40
`define OFMEC_REG_MODE      8'h45
`define OFMEC_REG_INTEN     8'h50
`define OFMEC_REG_STATUS    8'h51

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OFMEC_RST_SLOW_TRIM 16'h0000
`define OFMEC_RST_FAST_TRIM 16'h425E
`define OFMEC_RST_ZERO      16'h0000

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define OFMEC_MODE_LSB   0
`define OFMEC_MODE_MSB   3
`define OFMEC_FMT_LSB    4
`define OFMEC_FMT_MSB    7
`define OFMEC_ASW_BIT    10
`define OFMEC_GIRQ_BIT   15
`define OFMEC_GDRV_BIT   14
`define OFMEC_GTHR_MSB   13
`define OFMEC_ST_ON_BIT  0
`define OFMEC_ST_OFF_BIT 1
`define OFMEC_ST_GST_BIT 2

// ----------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------
`define OFMEC_MODE_STBY 4'h0
`define OFMEC_MODE_PROX 4'h1
`define OFMEC_MODE_GEST 4'h8

// ----------------------------------------------------------------
// serial port
// ----------------------------------------------------------------
`define OFMEC_DEV_ADDR  7'h5C
`define OFMEC_BIT_LAST  4'h8
`define OFMEC_BIT_ACK   4'h9

`endif

// >>> verilog/ofmec_top.v
// optical mode controller: serial register port, modes, proximity and gesture events
`timescale 1ns/100ps
`default_nettype none
`include "ofmec_defines.vh"

module ofmec_top (
  // clock and reset
  input  wire        CLK_I,
  input  wire        SRST_I,
  // serial register port
  input  wire        SCL_I,
  input  wire        SDA_I,
  output wire        SDA_O,
  output reg         SDA_OE_O,
  // sensor channel results
  input  wire [15:0] CH0_I,
  input  wire [15:0] CH1_I,
  input  wire [15:0] CH2_I,
  input  wire [15:0] CH3_I,
  input  wire        SMP_VLD_I,
  // acquisition control
  output wire        ACQ_EN_O,
  output reg         GEST_SET_O,
  output reg  [15:0] SAMP_CTRL_O,
  output reg  [3:0]  FIFO_FMT_O,
  output reg  [15:0] SLOW_TRIM_O,
  output reg  [15:0] FAST_TRIM_O,
  output reg         CAPTURE_O,
  // events
  output wire        INT_O
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] M_IDLE = 4'b0001;
  localparam [3:0] M_STBY = 4'b0010;
  localparam [3:0] M_PROX = 4'b0100;
  localparam [3:0] M_GEST = 4'b1000;

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_ADDR = 5'b00010;
  localparam [4:0] S_REG  = 5'b00100;
  localparam [4:0] S_WR   = 5'b01000;
  localparam [4:0] S_RD   = 5'b10000;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [3:0] mode_dec;
    input [3:0] fld;
    begin
      case (fld)
        `OFMEC_MODE_STBY: mode_dec = M_STBY;
        `OFMEC_MODE_PROX: mode_dec = M_PROX;
        `OFMEC_MODE_GEST: mode_dec = M_GEST;
        default:          mode_dec = M_IDLE;
      endcase
    end
  endfunction

  function [15:0] sum4;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    input [15:0] d;
    reg   [17:0] s;
    begin
      s = {2'b00, a} + {2'b00, b} + {2'b00, c} + {2'b00, d};
      // saturate so the intensity stays 16-bit wide
      sum4 = (s[17:16] != 2'b00) ? 16'hFFFF : s[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync_ff;
  reg [1:0] sda_sync_ff;
  reg       scl_d_ff;
  reg       sda_d_ff;

  always @(posedge CLK_I) begin
    scl_sync_ff <= {scl_sync_ff[0], SCL_I};
    sda_sync_ff <= {sda_sync_ff[0], SDA_I};
    scl_d_ff    <= scl_sync_ff[1];
    sda_d_ff    <= sda_sync_ff[1];
  end

  wire scl_rise = scl_sync_ff[1] & ~scl_d_ff;
  wire scl_fall = ~scl_sync_ff[1] & scl_d_ff;
  wire start_c  = scl_sync_ff[1] & scl_d_ff & ~sda_sync_ff[1] & sda_d_ff;
  wire stop_c   = scl_sync_ff[1] & scl_d_ff & sda_sync_ff[1] & ~sda_d_ff;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] on_thr_ff;
  reg [15:0] off_thr_ff;
  reg [15:0] asw_thr_ff;
  reg [15:0] gtrig_ff;
  reg [15:0] mode_cfg_ff;
  reg [15:0] inten_ff;
  reg [2:0]  status_ff;
  reg [3:0]  mode_st_ff;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  reg [4:0]  st_ff;
  reg [3:0]  cnt_ff;
  reg [7:0]  sh_ff;
  reg [7:0]  tx_ff;
  reg [7:0]  ptr_ff;
  reg [7:0]  hi_ff;
  reg        lo_next_ff;
  reg        mack_ff;
  reg        wr_stb_ff;
  reg [7:0]  wr_addr_ff;
  reg [15:0] wr_data_ff;

  // a process, not a function call, so register updates reach it at once
  reg  [15:0] rd_word;

  always @* begin
    case (ptr_ff)
      `OFMEC_REG_SLOW_TRIM: rd_word = SLOW_TRIM_O;
      `OFMEC_REG_FAST_TRIM: rd_word = FAST_TRIM_O;
      `OFMEC_REG_ON_THR:    rd_word = on_thr_ff;
      `OFMEC_REG_OFF_THR:   rd_word = off_thr_ff;
      `OFMEC_REG_ASW_THR:   rd_word = asw_thr_ff;
      `OFMEC_REG_GTRIG:     rd_word = gtrig_ff;
      `OFMEC_REG_SAMP:      rd_word = SAMP_CTRL_O;
      `OFMEC_REG_MODE:      rd_word = mode_cfg_ff;
      `OFMEC_REG_INTEN:     rd_word = inten_ff;
      `OFMEC_REG_STATUS:    rd_word = {13'h0000, status_ff};
      default:              rd_word = 16'h0000;
    endcase
  end
  wire        stby_wr = (ptr_ff == `OFMEC_REG_MODE) &&
                        (sh_ff[3:0] == `OFMEC_MODE_STBY);

  // open drain: the line is only ever pulled low
  assign SDA_O = 1'b0;

  always @(posedge CLK_I) begin
    wr_stb_ff <= 1'b0;
    if (SRST_I) begin
      st_ff      <= S_IDLE;
      cnt_ff     <= 4'h0;
      sh_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      ptr_ff     <= 8'h00;
      hi_ff      <= 8'h00;
      lo_next_ff <= 1'b0;
      mack_ff    <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 16'h0000;
      SDA_OE_O   <= 1'b0;
    end else if (start_c) begin
      st_ff    <= S_ADDR;
      cnt_ff   <= 4'h0;
      SDA_OE_O <= 1'b0;
    end else if (stop_c) begin
      st_ff    <= S_IDLE;
      SDA_OE_O <= 1'b0;
    end else if (st_ff != S_IDLE) begin
      if (scl_rise) begin
        if (cnt_ff < `OFMEC_BIT_LAST)
          sh_ff <= {sh_ff[6:0], sda_sync_ff[1]};
        else
          mack_ff <= ~sda_sync_ff[1];
        cnt_ff <= cnt_ff + 4'h1;
      end else if (scl_fall) begin
        if (cnt_ff == `OFMEC_BIT_LAST) begin
          SDA_OE_O <= 1'b0;
          case (st_ff)
            S_ADDR: begin
              if (sh_ff[7:1] == `OFMEC_DEV_ADDR) begin
                SDA_OE_O   <= 1'b1;
                st_ff      <= sh_ff[0] ? S_RD : S_REG;
                lo_next_ff <= 1'b0;
              end else begin
                st_ff <= S_IDLE;
              end
            end
            S_REG: begin
              ptr_ff     <= sh_ff;
              SDA_OE_O   <= 1'b1;
              st_ff      <= S_WR;
              lo_next_ff <= 1'b0;
            end
            S_WR: begin
              if (!lo_next_ff) begin
                hi_ff      <= sh_ff;
                SDA_OE_O   <= 1'b1;
                lo_next_ff <= 1'b1;
              end else begin
                wr_stb_ff  <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= {hi_ff, sh_ff};
                SDA_OE_O   <= ~stby_wr;
                ptr_ff     <= ptr_ff + 8'h01;
                lo_next_ff <= 1'b0;
              end
            end
            default: ;
          endcase
        end else if (cnt_ff == `OFMEC_BIT_ACK) begin
          cnt_ff   <= 4'h0;
          SDA_OE_O <= 1'b0;
          // a read starts after the address ack or after a master ack
          if (st_ff == S_RD && (SDA_OE_O || mack_ff)) begin
            tx_ff      <= lo_next_ff ? rd_word[7:0] : rd_word[15:8];
            SDA_OE_O   <= lo_next_ff ? ~rd_word[7] : ~rd_word[15];
            lo_next_ff <= ~lo_next_ff;
            if (lo_next_ff)
              ptr_ff <= ptr_ff + 8'h01;
          end else if (st_ff == S_RD) begin
            st_ff <= S_IDLE;
          end
        end else if (st_ff == S_RD) begin
          tx_ff    <= {tx_ff[6:0], 1'b0};
          SDA_OE_O <= ~tx_ff[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // intensity and events
  // ----------------------------------------------------------------
  reg        near_ff;
  reg        trig_ff;
  reg [15:0] prev_ff;

  wire        in_prox = (mode_st_ff == M_PROX);
  wire        in_gest = (mode_st_ff == M_GEST);
  wire        acq     = in_prox | in_gest;
  wire        vld     = SMP_VLD_I & acq;
  wire [15:0] inten   = sum4(CH0_I, CH1_I, CH2_I, CH3_I);
  wire [15:0] gthr    = {2'b00, gtrig_ff[`OFMEC_GTHR_MSB:0]};
  wire [15:0] delta   = inten - prev_ff;
  wire        g_abs   = inten > gthr;
  wire        g_drv   = (inten > prev_ff) && (delta > gthr);
  wire        g_cond  = gtrig_ff[`OFMEC_GDRV_BIT] ? g_drv : g_abs;

  wire on_evt  = vld & in_prox & ~near_ff & (inten > on_thr_ff);
  wire off_evt = vld & in_prox & near_ff & (inten < off_thr_ff);
  wire gst_evt = vld & in_gest & g_cond & ~trig_ff;
  wire asw_evt = vld & in_prox & mode_cfg_ff[`OFMEC_ASW_BIT] &
                 (inten >= asw_thr_ff);

  assign ACQ_EN_O = acq;
  assign INT_O    = |status_ff;

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      near_ff   <= 1'b0;
      trig_ff   <= 1'b0;
      prev_ff   <= 16'h0000;
      inten_ff  <= 16'h0000;
      CAPTURE_O <= 1'b0;
    end else begin
      CAPTURE_O <= vld & in_gest & g_cond;
      if (vld) begin
        prev_ff  <= inten;
        inten_ff <= inten;
        trig_ff  <= in_gest & g_cond;
      end
      if (on_evt)
        near_ff <= 1'b1;
      else if (off_evt)
        near_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register file and mode control
  // ----------------------------------------------------------------
  wire mode_wr = wr_stb_ff && (wr_addr_ff == `OFMEC_REG_MODE);
  // standby freezes everything but the mode register itself
  wire reg_wr  = wr_stb_ff && (mode_st_ff != M_STBY);
  wire [2:0] st_set = {gst_evt & gtrig_ff[`OFMEC_GIRQ_BIT],
                       off_evt, on_evt};
  wire [2:0] st_clr = (reg_wr && wr_addr_ff == `OFMEC_REG_STATUS) ?
                      wr_data_ff[2:0] : 3'b000;

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      SLOW_TRIM_O <= `OFMEC_RST_SLOW_TRIM;
      FAST_TRIM_O <= `OFMEC_RST_FAST_TRIM;
      on_thr_ff   <= `OFMEC_RST_ZERO;
      off_thr_ff  <= `OFMEC_RST_ZERO;
      asw_thr_ff  <= `OFMEC_RST_ZERO;
      gtrig_ff    <= `OFMEC_RST_ZERO;
      SAMP_CTRL_O <= `OFMEC_RST_ZERO;
      mode_cfg_ff <= `OFMEC_RST_ZERO;
      status_ff   <= 3'b000;
      mode_st_ff  <= M_IDLE;
    end else begin
      status_ff <= (status_ff & ~st_clr) | st_set;
      if (mode_wr) begin
        mode_cfg_ff <= wr_data_ff;
        mode_st_ff  <= mode_dec(wr_data_ff[3:0]);
      end else if (asw_evt) begin
        mode_cfg_ff[3:0] <= `OFMEC_MODE_GEST;
        mode_st_ff       <= M_GEST;
      end
      if (reg_wr) begin
        case (wr_addr_ff)
          `OFMEC_REG_SLOW_TRIM: SLOW_TRIM_O <= wr_data_ff;
          `OFMEC_REG_FAST_TRIM: FAST_TRIM_O <= wr_data_ff;
          `OFMEC_REG_ON_THR:    on_thr_ff   <= wr_data_ff;
          `OFMEC_REG_OFF_THR:   off_thr_ff  <= wr_data_ff;
          `OFMEC_REG_ASW_THR:   asw_thr_ff  <= wr_data_ff;
          `OFMEC_REG_GTRIG:     gtrig_ff    <= wr_data_ff;
          `OFMEC_REG_SAMP:      SAMP_CTRL_O <= wr_data_ff;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      GEST_SET_O <= 1'b0;
      FIFO_FMT_O <= 4'h0;
    end else begin
      GEST_SET_O <= in_gest;
      FIFO_FMT_O <= mode_cfg_ff[`OFMEC_FMT_MSB:`OFMEC_FMT_LSB];
    end
  end

endmodule // ofmec_top
`default_nettype wire

// >>> tb/ofmec_checker.sv
// port checker for the optical mode controller
`timescale 1ns/100ps
`default_nettype none
module ofmec_checker (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  // watched ports
  input wire logic        SCL_I,
  input wire logic        SDA_OE_O,
  input wire logic        SMP_VLD_I,
  input wire logic        ACQ_EN_O,
  input wire logic        GEST_SET_O,
  input wire logic [3:0]  FIFO_FMT_O,
  input wire logic [15:0] FAST_TRIM_O,
  input wire logic        CAPTURE_O,
  input wire logic        INT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // ----
  // assertions
  // ----
  a_reset_state: assert property ($fell(SRST_I) |->
    !ACQ_EN_O && !INT_O && !GEST_SET_O && !CAPTURE_O &&
    FAST_TRIM_O == 16'h425E) else $error("bad state after reset");
  a_int_cause: assert property ($rose(INT_O) |->
    $past(SMP_VLD_I && ACQ_EN_O)) else $error("event without sample");
  a_capture_cause: assert property (CAPTURE_O |->
    $past(SMP_VLD_I && ACQ_EN_O)) else $error("capture without sample");
  // the port only moves its data line while the clock is low
  a_oe_scl_low: assert property ($changed(SDA_OE_O) |->
    !$past(SCL_I, 2)) else $error("data line moved with clock high");
  a_int_fall_scl: assert property ($fell(INT_O) |->
    !$past(SCL_I, 2)) else $error("interrupt dropped without write");
  a_acq_rise_scl: assert property ($rose(ACQ_EN_O) |->
    !$past(SCL_I, 2)) else $error("acquisition began without write");
  a_fmt_scl: assert property ($changed(FIFO_FMT_O) |->
    !$past(SCL_I, 3)) else $error("format moved without write");
  a_gest_acq: assert property ($rose(GEST_SET_O) |->
    $past(ACQ_EN_O)) else $error("gesture set while not acquiring");
  c_int: cover property ($rose(INT_O));
  c_cap: cover property (CAPTURE_O);
  c_gest: cover property ($rose(GEST_SET_O));
endmodule // ofmec_checker
bind ofmec_top ofmec_checker i_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .SCL_I(SCL_I), .SDA_OE_O(SDA_OE_O), .SMP_VLD_I(SMP_VLD_I),
  .ACQ_EN_O(ACQ_EN_O), .GEST_SET_O(GEST_SET_O), .FIFO_FMT_O(FIFO_FMT_O),
  .FAST_TRIM_O(FAST_TRIM_O), .CAPTURE_O(CAPTURE_O), .INT_O(INT_O));
`default_nettype wire

// >>> tb/ofmec_host.sv
// host model on the serial register port
`timescale 1ns/100ps
`default_nettype none
`include "ofmec_defines.vh"
module ofmec_host (
  // clock and pins
  input  wire logic clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_pull
);
  logic [15:0] rd_word;
  logic        rd_vld;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_vld = 1'b0;
  end
  // ----
  // pin steps of two clocks, eight clocks per bit
  // ----
  task automatic st;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic bx(input logic b, output logic q);
    sda_pull = !b;
    st;
    scl = 1'b1;
    st;
    st;
    q = sda;
    scl = 1'b0;
    st;
  endtask
  // extra step lets the device release before the clock rises
  task automatic start;
    sda_pull = 1'b0;
    st;
    st;
    scl = 1'b1;
    st;
    sda_pull = 1'b1;
    st;
    scl = 1'b0;
    st;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    st;
    scl = 1'b1;
    st;
    sda_pull = 1'b0;
    st;
  endtask
  task automatic xb(input logic [7:0] d, input logic ma,
                    output logic [7:0] q, output logic nk);
    for (int i = 7; i >= 0; i--)
      bx(d[i], q[i]);
    bx(ma, nk);
  endtask
  // a missing acknowledge never stops the transfer
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    output logic [3:0] nk);
    logic [7:0] q;
    start;
    xb({`OFMEC_DEV_ADDR, 1'b0}, 1'b1, q, nk[3]);
    xb(a, 1'b1, q, nk[2]);
    xb(v[15:8], 1'b1, q, nk[1]);
    xb(v[7:0], 1'b1, q, nk[0]);
    stop;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] q;
    logic       k;
    start;
    xb({`OFMEC_DEV_ADDR, 1'b0}, 1'b1, q, k);
    xb(a, 1'b1, q, k);
    start;
    xb({`OFMEC_DEV_ADDR, 1'b1}, 1'b1, q, k);
    xb(8'hFF, 1'b0, rd_word[15:8], k);
    xb(8'hFF, 1'b1, rd_word[7:0], k);
    stop;
    rd_vld = 1'b1;
    @(posedge clk);
    #1;
    rd_vld = 1'b0;
  endtask
endmodule // ofmec_host
`default_nettype wire

// >>> tb/tb_ofmec_top.sv
// self-checking bench for the optical mode controller
`timescale 1ns/100ps
`default_nettype none
`include "ofmec_defines.vh"
module tb_ofmec_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        smp = 1'b0;
  logic [15:0] ch [4] = '{4{16'h0000}};
  logic [15:0] samp, strim, ftrim, r, s;
  logic [3:0]  fmt, nk;
  logic        sda_o, sda_oe, acq, gset, cap, intr, scl, pull;
  logic [15:0] expq [$];
  int          n_mismatch = 0, checks = 0, ncap = 0, seed = 79131;
  wire         sda = !(pull || (sda_oe && !sda_o));
  always #4 clk = !clk;
  ofmec_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
  ofmec_top i_dut (.CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .CH0_I(ch[0]), .CH1_I(ch[1]),
    .CH2_I(ch[2]), .CH3_I(ch[3]), .SMP_VLD_I(smp), .ACQ_EN_O(acq),
    .GEST_SET_O(gset), .SAMP_CTRL_O(samp), .FIFO_FMT_O(fmt),
    .SLOW_TRIM_O(strim), .FAST_TRIM_O(ftrim), .CAPTURE_O(cap),
    .INT_O(intr));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("BAD %0t expected %h got %h", $time, e, a);
    end
  endtask
  function automatic logic [15:0] b(input logic x);
    return {15'h0000, x};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] v,
                   input logic [3:0] e);
    i_host.wr(a, v, nk);
    chk({12'h000, e}, {12'h000, nk});
  endtask
  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    i_host.rd(a);
  endtask
  task automatic fire;
    smp = 1'b1;
    cyc(1);
    smp = 1'b0;
    cyc(3);
  endtask
  task automatic pv(input logic [15:0] v);
    ch = '{v, 16'h0000, 16'h0000, 16'h0000};
    fire;
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (cap === 1'b1)
      ncap++;
    if (i_host.rd_vld === 1'b1 && expq.size() == 0) begin
      n_mismatch++;
      $display("BAD %0t read without expected value", $time);
    end else if (i_host.rd_vld === 1'b1) begin
      chk(expq.pop_front(), i_host.rd_word);
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    stop_test;
  end
  // ----
  // scenarios
  // ----
  initial begin
    cyc(8);
    srst = 1'b0;
    cyc(4);
    chk(16'h0000, b(acq));
    chk(16'h425E, ftrim);
    chk(16'h0000, strim);
    pv(16'hFFFF);
    chk(16'h0000, b(intr));
    rdx(`OFMEC_REG_FAST_TRIM, 16'h425E);
    rdx(8'h33, 16'h0000);
    w(`OFMEC_REG_ON_THR, 16'h0100, 4'h0);
    w(`OFMEC_REG_OFF_THR, 16'h0080, 4'h0);
    r = 16'($random(seed));
    w(`OFMEC_REG_SAMP, r, 4'h0);
    chk(r, samp);
    w(`OFMEC_REG_MODE, 16'h0031, 4'h0);
    chk(16'h0001, b(acq));
    chk(16'h0000, b(gset));
    chk(16'h0003, {12'h000, fmt});
    s = 16'h0000;
    foreach (ch[i]) begin
      ch[i] = 16'h0100 + 16'($random(seed) & 16'h03FF);
      s += ch[i];
    end
    fire;
    chk(16'h0001, b(intr));
    rdx(`OFMEC_REG_INTEN, s);
    rdx(`OFMEC_REG_STATUS, 16'h0001);
    w(`OFMEC_REG_STATUS, 16'h0001, 4'h0);
    chk(16'h0000, b(intr));
    pv(16'h0FFF);
    chk(16'h0000, b(intr));
    pv(16'h0000);
    rdx(`OFMEC_REG_STATUS, 16'h0002);
    w(`OFMEC_REG_STATUS, 16'h0002, 4'h0);
    w(`OFMEC_REG_MODE, 16'h0000, 4'h1);
    chk(16'h0000, b(acq));
    pv(16'hFFFF);
    chk(16'h0000, b(intr));
    w(`OFMEC_REG_ON_THR, 16'h1234, 4'h0);
    rdx(`OFMEC_REG_ON_THR, 16'h0100);
    w(`OFMEC_REG_MODE, 16'h0008, 4'h0);
    chk(16'h0001, b(acq));
    chk(16'h0001, b(gset));
    w(`OFMEC_REG_GTRIG, 16'h8400, 4'h0);
    ncap = 0;
    pv(16'h0000);
    pv(16'h0800);
    rdx(`OFMEC_REG_STATUS, 16'h0004);
    w(`OFMEC_REG_STATUS, 16'h0004, 4'h0);
    w(`OFMEC_REG_GTRIG, 16'hC100, 4'h0);
    pv(16'h0850);
    pv(16'h0A00);
    rdx(`OFMEC_REG_STATUS, 16'h0004);
    chk(16'h0002, 16'(ncap));
    w(`OFMEC_REG_ASW_THR, 16'h0300, 4'h0);
    w(`OFMEC_REG_MODE, 16'h0401, 4'h0);
    pv(16'h02FF);
    chk(16'h0000, b(gset));
    pv(16'h0300);
    chk(16'h0001, b(gset));
    rdx(`OFMEC_REG_MODE, 16'h0408);
    w(`OFMEC_REG_MODE, 16'h0003, 4'h0);
    chk(16'h0000, b(acq));
    w(`OFMEC_REG_SLOW_TRIM, r | 16'h0001, 4'h0);
    chk(r | 16'h0001, strim);
    srst = 1'b1;
    cyc(4);
    srst = 1'b0;
    cyc(4);
    chk(16'h0000, b(acq));
    chk(16'h425E, ftrim);
    chk(16'h0000, strim);
    chk(16'h0000, 16'(expq.size()));
    stop_test;
  end
endmodule // tb_ofmec_top
`default_nettype wire
